// [src/dac_act_cal.sv]
// Command decode, mode registers and calibration read path of the device
`timescale 1ns/1ps
`default_nettype none

// Beat buffer between burst source and pin stage
module dac_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // Refuse shapes the pointer logic cannot serve
  if (DEPTH < 2 || W < 1) begin : g_bad_shape
    $error("dac_fifo needs DEPTH of 2 or more and W of 1 or more");
  end

  // Whole state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } dac_fifo_st_t;

  dac_fifo_st_t q; // Registered state
  dac_fifo_st_t d; // Next state
  logic push; // Word accepted
  logic pop; // Word delivered

  // Honest flags straight from the fill count
  assign in_ready = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    // Simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (!nrst) begin
      d = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    q <= d;
  end
endmodule

module dac_act_cal
  import dac_pkg::*;
#(
  parameter int BEAT_DIV = 2,
  parameter int FIFO_DEPTH = 4,
  parameter int RD_LAT = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs,
  input wire logic [5:0] ca,
  input wire logic [7:0] repair_avail,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe,
  output logic [1:0] dmi_o,
  output logic [1:0] dmi_oe,
  output logic act_strobe,
  output logic [2:0] act_bank,
  output logic [ROW_W-1:0] act_row,
  output logic [7:0] bank_open
);

  // Refuse settings the counters cannot hold
  if (BEAT_DIV < 1 || BEAT_DIV > 255 || RD_LAT < 0 || RD_LAT > 255) begin : g_bad_par
    $error("dac_act_cal needs BEAT_DIV 1..255 and RD_LAT 0..255");
  end

  localparam int BW = $bits(dac_beat_t);

  // Whole state of the block
  typedef struct packed {
    logic cs_s1; // First sync stage, read only by the second
    logic cs_s2;
    logic [5:0] ca_s1;
    logic [5:0] ca_s2;
    logic beat_b; // Next sampled edge is the second beat
    logic [5:0] beat_a; // First beat kept for decode
    logic act1_seen; // First half of an activate held
    logic [2:0] act1_bank;
    logic [6:0] act1_row;
    logic mrw1_seen; // First half of a register write held
    logic mrw_op7;
    logic [5:0] mrw_ma;
    logic [7:0] cal_a; // Pattern A
    logic [7:0] cal_b; // Pattern B
    logic [7:0] inv_lo; // Invert mask, lanes 7..0
    logic [7:0] inv_hi; // Invert mask, lanes 15..8
    logic [7:0] io_cfg; // Holds the read inversion enable
    dac_gen_t gen; // Burst source state
    logic [3:0] gen_cnt; // Beat index within the burst
    logic [7:0] gen_lat; // Cycles left before the first beat
    logic [7:0] mrr_data; // Byte captured for a register read
    logic [7:0] div_cnt; // Beat rate divider
    dac_beat_t pin; // Beat on the pins
    logic pin_en; // Data lanes driven
    dac_act_t act; // Activation report
    logic [7:0] bank_open;
  } dac_state_t;

  dac_state_t q; // Registered state
  dac_state_t d; // Next state
  dac_beat_t gen_beat; // Beat offered to the buffer
  logic gen_valid; // Source has a beat ready
  logic fifo_ready; // Buffer has room
  logic fifo_valid; // Buffer holds a beat
  logic [BW-1:0] fifo_data; // Head of the buffer
  logic beat_tick; // One-cycle enable at the beat rate
  logic [15:0] cal_stream; // Pattern A first, then B

  // Outputs come straight from state flops
  assign dq_o = q.pin.dq;
  assign dq_oe = {16{q.pin_en}};
  assign dmi_o = q.pin.dmi;
  assign dmi_oe = {2{q.pin.dmi_en}};
  assign act_strobe = q.act.strobe;
  assign act_bank = q.act.bank;
  assign act_row = q.act.row;
  assign bank_open = q.bank_open;

  // Divider pulse paces the pin stage; with BEAT_DIV above 1 it is slower than the source so the buffer fills
  assign beat_tick = (q.div_cnt == 8'(BEAT_DIV - 1));

  // Low byte goes out first, so A sits in the low half
  assign cal_stream = {q.cal_b, q.cal_a};

  // Beat built from the current burst position
  always_comb begin
    gen_beat = '0;
    gen_valid = (q.gen != GEN_IDLE) && (q.gen_lat == '0);
    if (q.gen == GEN_CAL) begin
      // Same bit on every lane, LSB of each byte first
      gen_beat.dq = {16{cal_stream[q.gen_cnt]}};
      // Per-lane invert on data lanes only
      gen_beat.dq = gen_beat.dq ^ {q.inv_hi, q.inv_lo};
      // Mask lanes carry the raw bit, no inversion of any kind
      gen_beat.dmi = {2{cal_stream[q.gen_cnt]}};
      // Mask lanes stay released when read inversion is off
      gen_beat.dmi_en = q.io_cfg[RBI_BIT];
    end else if (q.gen == GEN_MRR && q.gen_cnt == '0) begin
      gen_beat.dq = {8'h00, q.mrr_data};
    end
  end

  // Register read lookup; write-only and reserved addresses read zero
  function automatic logic [7:0] mr_read(input logic [5:0] ma, input dac_state_t s,
                                         input logic [7:0] rep);
    logic [7:0] r;
    r = 8'h00;
    unique case (ma)
      MA_REPAIR: r = rep;
      MA_IO_CONFIG: r = s.io_cfg;
      MA_LANE_INV_LO: r = s.inv_lo;
      MA_LANE_INV_HI: r = s.inv_hi;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    d = q;
    // Pins pass two flops before any decode looks at them
    d.cs_s1 = cs;
    d.cs_s2 = q.cs_s1;
    d.ca_s1 = ca;
    d.ca_s2 = q.ca_s1;
    d.act.strobe = 1'b0;

    // Command framing: chip select marks the first beat
    if (!q.beat_b) begin
      if (q.cs_s2) begin
        d.beat_a = q.ca_s2;
        d.beat_b = 1'b1;
      end
    end else begin
      d.beat_b = 1'b0;
      // Half commands only survive into the very next command
      d.act1_seen = 1'b0;
      d.mrw1_seen = 1'b0;
      if (q.beat_a[1:0] == CMD_ACT1) begin
        // First half: bank and upper row bits
        d.act1_seen = 1'b1;
        d.act1_bank = q.ca_s2[2:0];
        d.act1_row = {q.beat_a[5:2], q.ca_s2[5:3]};
      end else if (q.beat_a[1:0] == CMD_ACT2) begin
        // Second half only counts right after the first
        if (q.act1_seen) begin
          d.act.strobe = 1'b1;
          d.act.bank = q.act1_bank;
          d.act.row = {q.act1_row, q.beat_a[5:2], q.ca_s2};
          d.bank_open[q.act1_bank] = 1'b1;
        end
      end else begin
        unique case (q.beat_a[4:0])
          CMD_MRW1: begin
            d.mrw1_seen = 1'b1;
            d.mrw_op7 = q.beat_a[5];
            d.mrw_ma = q.ca_s2;
          end
          CMD_MRW2: begin
            if (q.mrw1_seen) begin
              unique case (q.mrw_ma)
                MA_CAL_A: d.cal_a = {q.mrw_op7, q.beat_a[5], q.ca_s2};
                MA_CAL_B: d.cal_b = {q.mrw_op7, q.beat_a[5], q.ca_s2};
                MA_LANE_INV_LO: d.inv_lo = {q.mrw_op7, q.beat_a[5], q.ca_s2};
                MA_LANE_INV_HI: d.inv_hi = {q.mrw_op7, q.beat_a[5], q.ca_s2};
                MA_IO_CONFIG: d.io_cfg = {q.mrw_op7, q.beat_a[5], q.ca_s2};
                // Test registers swallow the data
                MA_TEST_A, MA_TEST_B: d.mrw_ma = q.mrw_ma;
                // Repair readout and reserved addresses ignore writes
                default: d.mrw_ma = q.mrw_ma;
              endcase
            end
          end
          CMD_MRR1: begin
            // A read arriving during a burst is dropped
            if (q.gen == GEN_IDLE) begin
              d.gen = GEN_MRR;
              d.gen_cnt = '0;
              d.gen_lat = 8'(RD_LAT);
              d.mrr_data = mr_read(q.ca_s2, q, repair_avail);
            end
          end
          CMD_MPC: begin
            if ({q.beat_a[5], q.ca_s2} == MPC_OP_CAL && q.gen == GEN_IDLE) begin
              d.gen = GEN_CAL;
              d.gen_cnt = '0;
              d.gen_lat = 8'(RD_LAT);
            end
          end
          CMD_PRE: begin
            // Bit 5 of the first beat closes every bank
            if (q.beat_a[5]) begin
              d.bank_open = '0;
            end else begin
              d.bank_open[q.ca_s2[2:0]] = 1'b0;
            end
          end
          default: d.beat_b = 1'b0;
        endcase
      end
    end

    // Burst source: latency countdown, then one beat per accepted push
    if (q.gen != GEN_IDLE) begin
      if (q.gen_lat != '0) begin
        d.gen_lat = q.gen_lat - 1'b1;
      end else if (fifo_ready) begin
        d.gen_cnt = q.gen_cnt + 1'b1;
        if (q.gen_cnt == LAST_BEAT) begin
          d.gen = GEN_IDLE;
        end
      end
    end

    // Pin stage takes one beat per divider pulse, idles released
    d.div_cnt = beat_tick ? 8'h00 : q.div_cnt + 1'b1;
    if (beat_tick) begin
      d.pin_en = fifo_valid;
      // Empty buffer clears the mask enable too, so it never outlives the data lanes
      d.pin = fifo_valid ? dac_beat_t'(fifo_data) : '0;
    end

    // Synchronous reset loads defaults
    if (!nrst) begin
      d = '0;
      d.gen = GEN_IDLE;
      d.cal_a = CAL_A_RST;
      d.cal_b = CAL_B_RST;
      d.inv_lo = LANE_INV_RST;
      d.inv_hi = LANE_INV_RST;
      d.io_cfg = IO_CONFIG_RST;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  // Beat buffer; back-pressure holds the burst source
  dac_fifo #(
    .W(BW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(gen_valid),
    .in_ready(fifo_ready),
    .in_data(gen_beat),
    .out_valid(fifo_valid),
    .out_ready(beat_tick),
    .out_data(fifo_data)
  );

endmodule

`default_nettype wire

// [src/dac_pkg.sv]
// Shared constants and types for the activate and calibration-pattern block
package dac_pkg;

  // Mode register addresses (6-bit MA field)
  localparam logic [5:0] MA_IO_CONFIG = 6'h03;
  localparam logic [5:0] MA_LANE_INV_LO = 6'h0F;
  localparam logic [5:0] MA_LANE_INV_HI = 6'h14;
  localparam logic [5:0] MA_REPAIR = 6'h19;
  localparam logic [5:0] MA_TEST_A = 6'h1E;
  localparam logic [5:0] MA_CAL_A = 6'h20;
  localparam logic [5:0] MA_TEST_B = 6'h27;
  localparam logic [5:0] MA_CAL_B = 6'h28;

  // Values after reset
  localparam logic [7:0] CAL_A_RST = 8'h5A;
  localparam logic [7:0] CAL_B_RST = 8'h3C;
  localparam logic [7:0] LANE_INV_RST = 8'h00;
  localparam logic [7:0] IO_CONFIG_RST = 8'h00;

  // Field positions
  localparam int RBI_BIT = 6;

  // Command codes on the first beat; MPC calibration operand across both beats
  localparam logic [1:0] CMD_ACT1 = 2'h1;
  localparam logic [1:0] CMD_ACT2 = 2'h3;
  localparam logic [4:0] CMD_MPC = 5'h00;
  localparam logic [4:0] CMD_PRE = 5'h10;
  localparam logic [4:0] CMD_MRW1 = 5'h06;
  localparam logic [4:0] CMD_MRW2 = 5'h16;
  localparam logic [4:0] CMD_MRR1 = 5'h0E;
  localparam logic [6:0] MPC_OP_CAL = 7'h43;

  // Row width and burst geometry
  localparam int ROW_W = 17;
  localparam logic [3:0] LAST_BEAT = 4'hF;

  // Read burst source
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_CAL = 2'b01,
    GEN_MRR = 2'b10
  } dac_gen_t;

  // One beat on the data lanes
  typedef struct packed {
    logic dmi_en;
    logic [1:0] dmi;
    logic [15:0] dq;
  } dac_beat_t;

  // Row activation report
  typedef struct packed {
    logic strobe;
    logic [2:0] bank;
    logic [ROW_W-1:0] row;
  } dac_act_t;

endpackage

// [test/dac_act_cal_checker.sv]
// Port-level assertions for the activate and calibration block
`timescale 1ns/1ps
`default_nettype none
module dac_act_cal_checker
  import dac_pkg::*;
#(
  parameter int BEAT_DIV = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs,
  input wire logic [5:0] ca,
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  input wire logic [1:0] dmi_o,
  input wire logic [1:0] dmi_oe,
  input wire logic act_strobe,
  input wire logic [2:0] act_bank,
  input wire logic [7:0] bank_open
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Cycles the data lanes have been enabled so far
  logic [7:0] run_q;
  // Counter restarts whenever the lanes go quiet
  always_ff @(posedge clk_sys) begin
    run_q <= (!nrst || !dq_oe[0]) ? 8'h00 : run_q + 8'h01;
  end
  a_oe_lanes_same: assert property ((dq_oe == 16'h0000) || (dq_oe == 16'hFFFF))
    else $error("data lane enables differ");
  a_burst_length: assert property ($fell(dq_oe[0]) |-> run_q == 16 * BEAT_DIV)
    else $error("burst not sixteen beats long");
  a_beat_hold: assert property ((BEAT_DIV > 1) && $rose(dq_oe[0]) |=> $stable(dq_o))
    else $error("first beat too short");
  a_dmi_raw_bit: assert property (dmi_oe != 2'h0 |-> dmi_o[0] == dmi_o[1])
    else $error("mask lanes disagree");
  a_dmi_with_data: assert property (dmi_oe != 2'h0 |-> dq_oe[0] && dmi_oe == 2'h3)
    else $error("mask lanes driven alone");
  a_strobe_pulse: assert property (act_strobe |=> !act_strobe)
    else $error("activate strobe too long");
  // Second half of an activate must complete in a few cycles
  a_act_done: assert property (cs && ca[1:0] == CMD_ACT2 && $past(cs, 2)
    && $past(ca[1:0], 2) == CMD_ACT1 |-> ##[2:6] act_strobe)
    else $error("activate not completed");
  a_strobe_opens: assert property (act_strobe |-> bank_open[act_bank])
    else $error("activated bank not open");
  a_open_cause: assert property ((bank_open & ~$past(bank_open)) != 8'h00 |-> act_strobe)
    else $error("bank opened without activate");
endmodule

bind dac_act_cal dac_act_cal_checker #(.BEAT_DIV(BEAT_DIV)) i_chk (.clk_sys(clk_sys),
  .nrst(nrst), .cs(cs), .ca(ca), .dq_o(dq_o), .dq_oe(dq_oe), .dmi_o(dmi_o),
  .dmi_oe(dmi_oe), .act_strobe(act_strobe), .act_bank(act_bank), .bank_open(bank_open));
`default_nettype wire

// [test/dac_ctrl_model.sv]
// Memory controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_model
  import dac_pkg::*;
#(
  parameter int TCK_NS = 20,
  parameter int FAW_NS = 40,
  parameter int RRD_CYC = 4,
  parameter int RP_CYC = 4,
  parameter int RPAB_CYC = 5
) (
  input wire logic clk_sys,
  output var logic cs,
  output var logic [5:0] ca
);
  // Window in whole cycles, rounded up
  localparam int FAW_CYC = (FAW_NS + TCK_NS - 1) / TCK_NS;
  // Gap per activate so five never share one window
  localparam int ACT_GAP = (RRD_CYC > FAW_CYC / 4 + 1) ? RRD_CYC : FAW_CYC / 4 + 1;
  // Quiet bus from time zero
  initial begin
    cs = 1'b0;
    ca = 6'h00;
  end
  // Two-beat command, select only on the first beat
  task automatic cmd(input logic [5:0] a, input logic [5:0] b);
    @(negedge clk_sys);
    cs = 1'b1;
    ca = a;
    @(negedge clk_sys);
    cs = 1'b0;
    ca = b;
  endtask
  // Idle bus flips every cycle so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      ca = ~ca;
    end
  endtask
  // Activate as two back-to-back halves; no read or write follows
  task automatic act(input logic [2:0] bank, input logic [16:0] row);
    cmd({row[16:13], CMD_ACT1}, {row[12:10], bank});
    cmd({row[9:6], CMD_ACT2}, row[5:0]);
    idle(ACT_GAP);
  endtask
  // Precharge one bank or all, then wait out recovery
  task automatic pre(input logic all, input logic [2:0] bank);
    cmd({all, CMD_PRE}, {3'h0, bank});
    idle(all ? RPAB_CYC : RP_CYC);
  endtask
  // Mode register write, keeping normal access spacing
  task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
    cmd({op[7], CMD_MRW1}, ma);
    cmd({op[6], CMD_MRW2}, op[5:0]);
    idle(2);
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the activate and calibration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dac_pkg::*;
  localparam int BD = 2;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] repair_avail = 8'hA5;
  logic cs;
  logic [5:0] ca;
  logic [15:0] dq_o;
  logic [15:0] dq_oe;
  logic [1:0] dmi_o;
  logic [1:0] dmi_oe;
  logic act_strobe;
  logic [2:0] act_bank;
  logic [ROW_W-1:0] act_row;
  logic [7:0] bank_open;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  dac_ctrl_model i_ctrl (.clk_sys(clk_sys), .cs(cs), .ca(ca));
  dac_act_cal #(.BEAT_DIV(BD)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .cs(cs), .ca(ca),
    .repair_avail(repair_avail), .dq_o(dq_o), .dq_oe(dq_oe), .dmi_o(dmi_o), .dmi_oe(dmi_oe),
    .act_strobe(act_strobe), .act_bank(act_bank), .act_row(act_row), .bank_open(bank_open));
  // One comparison, unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts, verdict, end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Bounded wait for the lanes to turn on
  task automatic wait_burst();
    int n;
    n = 0;
    while (dq_oe[0] !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk(dq_oe, 16'hFFFF);
  endtask
  // Calibration burst: {b,a} LSB first, masks on data lanes only
  task automatic cal_run(input logic [7:0] a, input logic [7:0] b, input logic [15:0] inv,
      input logic dmi_on);
    logic [15:0] pat;
    pat = {b, a};
    i_ctrl.cmd({MPC_OP_CAL[6], CMD_MPC}, MPC_OP_CAL[5:0]);
    i_ctrl.idle(1);
    wait_burst();
    for (int k = 0; k < 16; k++) begin
      chk(dq_o, {16{pat[k]}} ^ inv);
      chk(dmi_oe, dmi_on ? 2'h3 : 2'h0);
      if (dmi_on) chk(dmi_o, {2{pat[k]}});
      repeat (BD) @(negedge clk_sys);
    end
    chk(dq_oe, 16'h0000);
  endtask
  // Repair readout follows the input; a write to it bounces off
  task automatic repair_read();
    i_ctrl.mrw(MA_REPAIR, 8'h00);
    i_ctrl.cmd({1'b0, CMD_MRR1}, MA_REPAIR);
    i_ctrl.idle(1);
    wait_burst();
    chk(dq_o[7:0], 8'hA5);
    chk(dmi_oe, 2'h0);
    // Calibration request inside the running burst must be dropped
    i_ctrl.cmd({MPC_OP_CAL[6], CMD_MPC}, MPC_OP_CAL[5:0]);
    repeat (38) @(negedge clk_sys);
    chk(dq_oe, 16'h0000);
  endtask
  // New patterns, junk to test and reserved places, masks on
  task automatic cal_written();
    i_ctrl.mrw(MA_CAL_A, 8'hC3);
    i_ctrl.mrw(MA_CAL_B, 8'h27);
    i_ctrl.mrw(MA_TEST_A, 8'hFF);
    i_ctrl.mrw(MA_TEST_B, 8'h00);
    i_ctrl.mrw(6'h1A, 8'h55);
    i_ctrl.mrw(MA_LANE_INV_LO, 8'h81);
    i_ctrl.mrw(MA_LANE_INV_HI, 8'h10);
    i_ctrl.mrw(MA_IO_CONFIG, 8'h40);
    cal_run(8'hC3, 8'h27, 16'h1081, 1'b1);
  endtask
  // Every bank opened, then single and all-bank precharge
  task automatic act_pre();
    for (int b = 0; b < 8; b++) begin
      i_ctrl.act(b[2:0], {b[2:0], 14'h2AAA});
      i_ctrl.idle(2);
      chk(act_bank, b[2:0]);
      chk(act_row, {b[2:0], 14'h2AAA});
    end
    chk(bank_open, 8'hFF);
    i_ctrl.pre(1'b0, 3'h5);
    chk(bank_open, 8'hDF);
    i_ctrl.pre(1'b1, 3'h0);
    chk(bank_open, 8'h00);
    // Second half with no first half in front opens nothing
    i_ctrl.cmd({4'h0, CMD_ACT2}, 6'h07);
    i_ctrl.idle(4);
    chk(bank_open, 8'h00);
    i_ctrl.act(3'h5, 17'h05543);
    i_ctrl.idle(2);
    chk(act_row, 17'h05543);
    chk(bank_open, 8'h20);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    i_ctrl.idle(3);
    cal_run(8'h5A, 8'h3C, 16'h0000, 1'b0);
    repair_read();
    cal_written();
    act_pre();
    report_and_stop();
  end
endmodule
`default_nettype wire
